/* wzc_top.sv */
`timescale 1ns/10ps
`default_nettype none
// Contract
// - current samples leave as signed 24-bit words at up to 26 kSPS
// - over-ranged current results clamp at 400000h and C00000h
// - current phase scaled by one plus 12-bit signed gain over 4096
// - energy path samples keep flowing while waveforms are captured
// - rate field at waveform mode bits 3-4 picks the output rate
// - waveform mode picks which current or voltage phase is captured
// - sample-ready mask set drives interrupt low on each new sample
// - waveform word goes out as three bytes, most significant first
// - interrupt holds until host reads clear-on-read status
// - with sample-ready mask clear the waveform register is not loaded
// - voltage modulator bit goes straight to the multiplier, unfiltered
// - voltage samples pass a 260 Hz single-pole low-pass before capture
// - filtered full-scale voltage swings between D70Bh and 28F5h
// - voltage sample fills low 16 bits, upper byte forced to zero
// - zero crossing uses the filtered voltage, not raw samples
// - negative-to-positive crossing sets that phase flag in status 7-9
// - zero-crossing flag reaches interrupt only with its mask bit set
// - reading clear-on-read status resets zero-crossing flags
// - each voltage phase has its own flag and mask bit
// - measurement mode phase-enable bits also gate crossing interrupts
module wzc_top #(
   parameter int IW = 24
) (
   // master clock domain
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // converter results, one strobe per 26 kSPS sample
   input  wire logic              smp_vld_i,
   input  wire logic [3*IW-1:0]   i_raw_i,
   input  wire logic [2:0]        i_ovr_i,
   input  wire logic [47:0]       v_raw_i,
   input  wire logic [2:0]        v_bit_i,
   // power path
   output logic [71:0]            i_pwr_o,
   output logic [2:0]             v_bit_o,
   // serial port
   input  wire logic              sclk_i,
   input  wire logic              cs_n_i,
   input  wire logic              din_i,
   output logic                   dout_o,
   output logic                   dout_oe_o,
   output logic                   irq_n_o,
   output logic                   irq_n_oe_o
);
   // ---------------- core datapath ----------------
   logic [71:0]  i_pwr_ff;
   logic [47:0]  v_lp_ff;
   logic [71:0]  v_acc_ff;
   logic [2:0]   v_neg_ff;
   logic [2:0]   v_bit_ff;
   logic [2:0]   zx_evt;
   logic [2:0]   dec_ff;
   logic         smp_vld_ff;
   logic [23:0]  wave_ff;
   logic [15:0]  status_ff;
   logic [15:0]  mask_ff;
   logic [7:0]   waveform_mode_register_ff;
   logic [7:0]   measurement_mode_register_ff;
   logic [35:0]  gain_ff;
   logic         irq_n_ff;
   logic         irq_oe_ff;

   // clamp limits must be known before the per-phase datapath uses them
   localparam logic [23:0] I_POS = wzc_pkg::I_POS_LIM;
   localparam logic [23:0] I_NEG = wzc_pkg::I_NEG_LIM;

   genvar p;
   generate
      for (p = 0; p < 3; p++) begin : g_ph
         logic signed [IW-1:0] raw;
         logic signed [23:0]   clip;
         logic signed [11:0]   g;
         logic signed [36:0]   prod;
         logic signed [25:0]   sum;
         logic signed [23:0]   scaled;
         logic signed [23:0]   vin;
         logic signed [23:0]   vacc;
         logic signed [23:0]   nxt_vacc;
         assign raw = i_raw_i[p*IW +: IW];
         assign g   = gain_ff[p*12 +: 12];
         always_comb begin
            if (i_ovr_i[p] && raw[IW-1])
               clip = I_NEG;
            else if (i_ovr_i[p] ||
                     ($signed(raw) > $signed(I_POS)))
               clip = I_POS;
            else if ($signed(raw) < $signed(I_NEG))
               clip = I_NEG;
            else
               clip = raw[23:0];
            prod = 37'(clip) * 37'(g);
            sum  = 26'(clip) + 26'(prod >>> wzc_pkg::GAIN_SHIFT);
            // limits compared signed, the negative one sign-extended
            if (sum > $signed(26'(I_POS)))
               scaled = I_POS;
            else if (sum < 26'($signed(I_NEG)))
               scaled = I_NEG;
            else
               scaled = sum[23:0];
         end
         // energy path runs on every sample regardless of capture
         always_ff @(posedge clk_i) begin
            if (rst_i)
               i_pwr_ff[p*24 +: 24] <= 24'h000000;
            else if (smp_vld_i)
               i_pwr_ff[p*24 +: 24] <= scaled;
         end
         // one-pole low-pass, extra fraction bits keep the slow pole exact
         assign vin  = {v_raw_i[p*16 +: 16], 8'h00};
         assign vacc = v_acc_ff[p*24 +: 24];
         assign nxt_vacc = vacc + ((vin - vacc) >>> wzc_pkg::LPF_SHIFT);
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               v_acc_ff[p*24 +: 24] <= 24'h000000;
               v_lp_ff[p*16 +: 16]  <= 16'h0000;
               v_neg_ff[p]          <= 1'b0;
            end else if (smp_vld_i) begin
               v_acc_ff[p*24 +: 24] <= nxt_vacc;
               v_lp_ff[p*16 +: 16]  <= nxt_vacc[23:8];
               v_neg_ff[p]          <= nxt_vacc[23];
            end
         end
         assign zx_evt[p] = smp_vld_i && v_neg_ff[p] && !nxt_vacc[23];
      end
   endgenerate

   // modulator bits bypass all filtering on their way to the multiplier
   always_ff @(posedge clk_i) begin
      if (rst_i)
         v_bit_ff <= 3'h0;
      else
         v_bit_ff <= v_bit_i;
   end

   // ---------------- waveform capture ----------------
   logic [1:0]  rate;
   logic [2:0]  dec_top;
   logic        dec_hit;
   logic [23:0] wsel;
   assign rate    = waveform_mode_register_ff[wzc_pkg::RATE_LSB +: 2];
   assign dec_top = 3'((4'h1 << rate) - 4'h1);
   assign dec_hit = smp_vld_ff && (dec_ff == dec_top);

   always_ff @(posedge clk_i) begin
      if (rst_i)
         dec_ff <= 3'h0;
      else if (smp_vld_ff)
         dec_ff <= dec_hit ? 3'h0 : 3'(dec_ff + 3'h1);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         smp_vld_ff <= 1'b0;
      else
         smp_vld_ff <= smp_vld_i;
   end

   always_comb begin
      unique case (wzc_pkg::wzc_src_e'(waveform_mode_register_ff[wzc_pkg::SEL_LSB +: 3]))
         wzc_pkg::WZC_SRC_IA: wsel = i_pwr_ff[23:0];
         wzc_pkg::WZC_SRC_IB: wsel = i_pwr_ff[47:24];
         wzc_pkg::WZC_SRC_IC: wsel = i_pwr_ff[71:48];
         wzc_pkg::WZC_SRC_VA: wsel = {8'h00, v_lp_ff[15:0]};
         wzc_pkg::WZC_SRC_VB: wsel = {8'h00, v_lp_ff[31:16]};
         wzc_pkg::WZC_SRC_VC: wsel = {8'h00, v_lp_ff[47:32]};
         default:             wsel = 24'h000000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         wave_ff <= 24'h000000;
      else if (dec_hit && mask_ff[wzc_pkg::SMP_BIT])
         wave_ff <= wsel;
   end

   // ---------------- link crossing ----------------
   logic [2:0]        wr_sy_ff;
   logic [2:0]        clr_sy_ff;
   logic [1:0]        cs_sy_ff;
   logic              wr_tgl_ff;
   logic              clr_tgl_ff;
   wzc_pkg::wzc_wr_s  wr_ff;
   wzc_pkg::wzc_snap_s snap_ff;
   logic [15:0]       clr_mask_ff;
   logic              wr_evt;
   logic              clr_evt;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_sy_ff  <= 3'h0;
         clr_sy_ff <= 3'h0;
         cs_sy_ff  <= 2'h3;
      end else begin
         wr_sy_ff  <= {wr_sy_ff[1:0], wr_tgl_ff};
         clr_sy_ff <= {clr_sy_ff[1:0], clr_tgl_ff};
         cs_sy_ff  <= {cs_sy_ff[0], cs_n_i};
      end
   end
   assign wr_evt  = wr_sy_ff[2] ^ wr_sy_ff[1];
   assign clr_evt = clr_sy_ff[2] ^ clr_sy_ff[1];

   // view stays frozen while a frame is open so the link reads stable words
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         snap_ff     <= '0;
         clr_mask_ff <= 16'h0000;
      end else if (cs_sy_ff[1]) begin
         snap_ff     <= {wave_ff, status_ff, mask_ff, waveform_mode_register_ff, measurement_mode_register_ff, gain_ff};
         clr_mask_ff <= status_ff;
      end
   end

   // ---------------- registers ----------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         waveform_mode_register_ff <= wzc_pkg::WAVEFORM_MODE_REGISTER_RST;
         measurement_mode_register_ff   <= wzc_pkg::MEASUREMENT_MODE_REGISTER_RST;
         mask_ff    <= wzc_pkg::MASK_RST;
         gain_ff    <= {3{wzc_pkg::GAIN_RST}};
      end else if (wr_evt) begin
         unique case (wr_ff.addr)
            wzc_pkg::A_WAVEFORM_MODE_REGISTER: waveform_mode_register_ff <= wr_ff.data[7:0];
            wzc_pkg::A_MEASUREMENT_MODE_REGISTER:   measurement_mode_register_ff   <= wr_ff.data[7:0];
            wzc_pkg::A_MASK:    mask_ff    <= wr_ff.data[15:0];
            wzc_pkg::A_GAIN_A:  gain_ff[11:0]  <= wr_ff.data[11:0];
            wzc_pkg::A_GAIN_B:  gain_ff[23:12] <= wr_ff.data[11:0];
            wzc_pkg::A_GAIN_C:  gain_ff[35:24] <= wr_ff.data[11:0];
            default: ;
         endcase
      end
   end

   // new events win over a clear arriving in the same cycle
   logic [15:0] set_bits;
   always_comb begin
      set_bits = 16'h0000;
      set_bits[wzc_pkg::ZX_LSB +: 3] = zx_evt;
      set_bits[wzc_pkg::SMP_BIT] = dec_hit && mask_ff[wzc_pkg::SMP_BIT];
   end
   always_ff @(posedge clk_i) begin
      if (rst_i)
         status_ff <= 16'h0000;
      else if (clr_evt)
         status_ff <= (status_ff & ~clr_mask_ff) | set_bits;
      else
         status_ff <= status_ff | set_bits;
   end

   logic [15:0] gate;
   always_comb begin
      gate = mask_ff;
      gate[wzc_pkg::ZX_LSB +: 3] = mask_ff[wzc_pkg::ZX_LSB +: 3] &
                                   measurement_mode_register_ff[wzc_pkg::ZXEN_LSB +: 3];
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_n_ff  <= 1'b1;
         irq_oe_ff <= 1'b0;
      end else begin
         irq_n_ff  <= ~|(status_ff & gate);
         irq_oe_ff <= |(status_ff & gate);
      end
   end

   // ---------------- serial port, link clock ----------------
   logic [5:0]  bcnt_ff;
   logic [6:0]  cmd_ff;
   logic [23:0] sh_ff;
   logic [23:0] wsh_ff;
   logic        dout_ff;
   logic        oe_ff;
   logic [1:0]  nby;
   logic [23:0] rdv;
   logic [5:0]  last_bit;
   logic [6:0]  cmd_cur;

   // on the eighth falling edge the last address bit is still on din
   assign cmd_cur = (bcnt_ff == 6'd7) ? {cmd_ff[5:0], din_i} : cmd_ff;

   // bytes carried by each register, data left-justified in sh_ff
   always_comb begin
      unique case (cmd_cur[5:0])
         wzc_pkg::A_WAVE: begin
            nby = 2'd3;
            rdv = snap_ff.wave;
         end
         wzc_pkg::A_STATUS, wzc_pkg::A_CLEAR_ON_READ_STATUS: begin
            nby = 2'd2;
            rdv = {snap_ff.status, 8'h00};
         end
         wzc_pkg::A_MASK: begin
            nby = 2'd2;
            rdv = {snap_ff.mask, 8'h00};
         end
         wzc_pkg::A_WAVEFORM_MODE_REGISTER: begin
            nby = 2'd1;
            rdv = {snap_ff.waveform_mode_register, 16'h0000};
         end
         wzc_pkg::A_MEASUREMENT_MODE_REGISTER: begin
            nby = 2'd1;
            rdv = {snap_ff.measurement_mode_register, 16'h0000};
         end
         wzc_pkg::A_GAIN_A: begin
            nby = 2'd2;
            rdv = {4'h0, snap_ff.gain[11:0], 8'h00};
         end
         wzc_pkg::A_GAIN_B: begin
            nby = 2'd2;
            rdv = {4'h0, snap_ff.gain[23:12], 8'h00};
         end
         wzc_pkg::A_GAIN_C: begin
            nby = 2'd2;
            rdv = {4'h0, snap_ff.gain[35:24], 8'h00};
         end
         default: begin
            nby = 2'd1;
            rdv = 24'h000000;
         end
      endcase
   end
   assign last_bit = 6'(6'd7 + 6'd8 * 6'(nby));

   // a frame that ends early simply aborts: the chip select resets it
   always_ff @(negedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         bcnt_ff <= 6'h00;
         cmd_ff  <= 7'h00;
         sh_ff   <= 24'h000000;
         wsh_ff  <= 24'h000000;
      end else begin
         if (bcnt_ff != 6'h3F)
            bcnt_ff <= 6'(bcnt_ff + 6'h01);
         if (bcnt_ff < 6'd8)
            cmd_ff <= {cmd_ff[5:0], din_i};
         if (bcnt_ff == 6'd7)
            sh_ff <= rdv;
         else
            sh_ff <= {sh_ff[22:0], 1'b0};
         if (bcnt_ff > 6'd7)
            wsh_ff <= {wsh_ff[22:0], din_i};
      end
   end

   // event toggles survive chip select so no request is lost
   always_ff @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_tgl_ff  <= 1'b0;
         clr_tgl_ff <= 1'b0;
         wr_ff      <= '0;
      end else if (!cs_n_i) begin
         if (bcnt_ff == 6'd7 && !cmd_cur[6] &&
             cmd_cur[5:0] == wzc_pkg::A_CLEAR_ON_READ_STATUS)
            clr_tgl_ff <= ~clr_tgl_ff;
         if (bcnt_ff == last_bit && cmd_ff[6]) begin
            wr_ff.addr <= cmd_ff[5:0];
            // written data stays right-justified, as the registers take it
            wr_ff.data <= {wsh_ff[22:0], din_i};
            wr_tgl_ff  <= ~wr_tgl_ff;
         end
      end
   end

   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         dout_ff <= 1'b0;
         oe_ff   <= 1'b0;
      end else begin
         dout_ff <= sh_ff[23];
         oe_ff   <= !cmd_ff[6] && bcnt_ff >= 6'd8 && bcnt_ff <= last_bit;
      end
   end

   assign i_pwr_o    = i_pwr_ff;
   assign v_bit_o    = v_bit_ff;
   assign dout_o     = dout_ff;
   assign dout_oe_o  = oe_ff;
   assign irq_n_o    = 1'b0;
   assign irq_n_oe_o = irq_oe_ff;

   // ---------------- checks ----------------
   zx_sets_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      zx_evt[0] |=> status_ff[wzc_pkg::ZX_LSB])
      else $error("crossing on phase a did not set its flag");
   clamp_pos_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $signed(i_pwr_ff[23:0]) <= $signed(I_POS))
      else $error("current sample above positive limit");
   clamp_neg_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $signed(i_pwr_ff[23:0]) >= $signed(I_NEG))
      else $error("current sample below negative limit");
   no_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !mask_ff[wzc_pkg::SMP_BIT] |=> $stable(wave_ff))
      else $error("waveform loaded with sample mask clear");
   volt_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(wave_ff) && $past(waveform_mode_register_ff[2:0]) >= 3'h3 |-> wave_ff[23:16] == 8'h00)
      else $error("voltage sample upper byte not zero");
   irq_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !irq_n_ff && !$past(clr_evt) && !$past(wr_evt) |=> !irq_n_ff)
      else $error("interrupt released without status read");
   zx_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      status_ff == 16'h0000 |=> irq_n_ff)
      else $error("interrupt with no flag set");
   smp_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
      dec_hit && mask_ff[wzc_pkg::SMP_BIT] && !clr_evt && !wr_evt |-> ##2 !irq_n_ff)
      else $error("sample ready did not raise interrupt");
   rate_div_a: assert property (@(posedge clk_i) disable iff (rst_i)
      dec_hit && rate == 2'h3 && !wr_evt |=> dec_ff == 3'h0 [*1] ##0 !dec_hit)
      else $error("decimator did not restart after capture");
   bit_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 v_bit_ff == $past(v_bit_i))
      else $error("modulator bit not passed through");
endmodule
`default_nettype wire

/* wzc_pkg.sv */
package wzc_pkg;
   // register addresses on the serial port
   localparam logic [5:0] A_WAVE     = 6'h01;
   localparam logic [5:0] A_MEASUREMENT_MODE_REGISTER    = 6'h0B;
   localparam logic [5:0] A_WAVEFORM_MODE_REGISTER  = 6'h0D;
   localparam logic [5:0] A_MASK     = 6'h10;
   localparam logic [5:0] A_STATUS   = 6'h11;
   localparam logic [5:0] A_CLEAR_ON_READ_STATUS  = 6'h12;
   localparam logic [5:0] A_GAIN_A   = 6'h20;
   localparam logic [5:0] A_GAIN_B   = 6'h21;
   localparam logic [5:0] A_GAIN_C   = 6'h22;
   // command byte
   localparam int CMD_WR_BIT = 7;
   // field positions
   localparam int RATE_LSB  = 3;
   localparam int SEL_LSB   = 0;
   localparam int ZX_LSB    = 7;
   localparam int SMP_BIT   = 10;
   localparam int ZXEN_LSB  = 4;
   // reset values
   localparam logic [7:0]  WAVEFORM_MODE_REGISTER_RST = 8'h00;
   localparam logic [7:0]  MEASUREMENT_MODE_REGISTER_RST   = 8'h70;
   localparam logic [15:0] MASK_RST    = 16'h0000;
   localparam logic [11:0] GAIN_RST    = 12'h000;
   // clamp limits and gain scaling
   localparam logic [23:0] I_POS_LIM = 24'h400000;
   localparam logic [23:0] I_NEG_LIM = 24'hC00000;
   localparam int GAIN_SHIFT = 12;
   // filter: pole at 260 Hz from a 26 kHz sample stream
   localparam int LPF_CORNER_HZ = 260;
   localparam int LPF_RATE_HZ   = 26000;
   localparam int LPF_SHIFT     = 4;
   localparam int LPF_FRAC      = 8;
   // waveform source selection
   typedef enum logic [2:0] {
      WZC_SRC_IA = 3'h0,
      WZC_SRC_IB = 3'h1,
      WZC_SRC_IC = 3'h2,
      WZC_SRC_VA = 3'h3,
      WZC_SRC_VB = 3'h4,
      WZC_SRC_VC = 3'h5
   } wzc_src_e;
   // write captured on the link, handed to the core
   typedef struct packed {
      logic [5:0]  addr;
      logic [23:0] data;
   } wzc_wr_s;
   // register view frozen for a serial frame
   typedef struct packed {
      logic [23:0] wave;
      logic [15:0] status;
      logic [15:0] mask;
      logic [7:0]  waveform_mode_register;
      logic [7:0]  measurement_mode_register;
      logic [35:0] gain;
   } wzc_snap_s;
endpackage

/* wzc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module wzc_host_model (
   // serial port, host side
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      din_o,
   input  wire logic dout_i
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      din_o  = 1'b0;
   end

   // one command frame; sclk only runs inside the frame
   task automatic xfer(input logic [7:0] cmd, input int nb, input logic [23:0] wd, output logic [23:0] rd);
      logic [31:0] sh;
      sh = {cmd, wd << (24 - 8 * nb)};
      rd = 24'h000000;
      cs_n_o = 1'b0;
      // register view needs a few master clocks to freeze
      #507;
      for (int i = 0; i < 8 + 8 * nb; i++) begin
         sclk_o = 1'b1;
         din_o  = sh[31-i];
         #6;
         if (i >= 8) begin
            rd = {rd[22:0], dout_i};
         end
         sclk_o = 1'b0;
         #6;
      end
      // released line must not look like held data
      din_o = ~din_o;
      #30;
      cs_n_o = 1'b1;
      #500;
   endtask
endmodule
`default_nettype wire

/* tb_waveform_sample_zero_cross.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module tb_waveform_sample_zero_cross;
   logic        clk_i;
   logic        rst_i;
   logic        smp_vld_i;
   logic [71:0] i_raw_i;
   logic [2:0]  i_ovr_i;
   logic [47:0] v_raw_i;
   logic [2:0]  v_bit_i;
   logic [71:0] i_pwr_o;
   logic [2:0]  v_bit_o;
   logic        sclk;
   logic        cs_n;
   logic        din;
   logic        dout_o;
   logic        dout_oe_o;
   logic        irq_n_o;
   logic        irq_n_oe_o;
   wire         irq_n = irq_n_oe_o ? irq_n_o : 1'b1;
   int          failures;
   int          check_count;
   int          seed;
   int          n;
   logic [11:0] gain [3];
   logic [23:0] rd;
   logic [23:0] old;
   logic [71:0] ir;
   logic [2:0]  ov;
   logic [2:0]  prev;

   wzc_top dut (.clk_i(clk_i), .rst_i(rst_i), .smp_vld_i(smp_vld_i), .i_raw_i(i_raw_i), .i_ovr_i(i_ovr_i),
                .v_raw_i(v_raw_i), .v_bit_i(v_bit_i), .i_pwr_o(i_pwr_o), .v_bit_o(v_bit_o), .sclk_i(sclk),
                .cs_n_i(cs_n), .din_i(din), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .irq_n_o(irq_n_o),
                .irq_n_oe_o(irq_n_oe_o));
   wzc_host_model hm (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout_o));

   function automatic logic [23:0] sat(input logic signed [47:0] x);
      if (x > 48'sh400000) return 24'h400000;
      if (x < -48'sh400000) return 24'hC00000;
      return x[23:0];
   endfunction

   function automatic logic [23:0] ipath(input logic [23:0] raw, input logic ovr, input logic [11:0] g);
      logic signed [47:0] c;
      c = 48'(signed'(raw));
      if (ovr) c = raw[23] ? -48'sh400000 : 48'sh400000;
      c = 48'(signed'(sat(c)));
      return sat(c + ((c * 48'(signed'(g))) >>> 12));
   endfunction

   task automatic wr(input logic [5:0] a, input int nb, input logic [23:0] d);
      logic [23:0] r;
      hm.xfer({2'b01, a}, nb, d, r);
   endtask

   task automatic rdr(input logic [5:0] a, input int nb);
      hm.xfer({2'b00, a}, nb, 24'h000000, rd);
   endtask

   // one converter strobe, then wait until irq has had time to move
   task automatic sample(input logic [71:0] i_r, input logic [2:0] o_v, input logic [47:0] v_r);
      @(posedge clk_i);
      smp_vld_i <= 1'b1;
      i_raw_i   <= i_r;
      i_ovr_i   <= o_v;
      v_raw_i   <= v_r;
      @(posedge clk_i);
      smp_vld_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
   endtask

   task automatic stop_test;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   initial begin
      repeat (100000) @(posedge clk_i);
      failures++;
      stop_test();
   end

   initial begin
      seed = 36;
      failures = 0;
      check_count = 0;
      // a real rising edge so the link logic sees its asynchronous reset
      rst_i = 1'b0;
      smp_vld_i = 1'b0;
      i_raw_i = 72'h0;
      i_ovr_i = 3'h0;
      v_raw_i = 48'h0;
      v_bit_i = 3'h0;
      #1 rst_i = 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      rdr(wzc_pkg::A_WAVEFORM_MODE_REGISTER, 1);
      `CHK(rd[7:0], wzc_pkg::WAVEFORM_MODE_REGISTER_RST)
      rdr(wzc_pkg::A_MEASUREMENT_MODE_REGISTER, 1);
      `CHK(rd[7:0], wzc_pkg::MEASUREMENT_MODE_REGISTER_RST)
      rdr(wzc_pkg::A_MASK, 2);
      `CHK(rd[15:0], wzc_pkg::MASK_RST)
      rdr(wzc_pkg::A_GAIN_B, 2);
      `CHK(rd[11:0], wzc_pkg::GAIN_RST)
      rdr(6'h3F, 1);
      `CHK(rd[7:0], 8'h00)
      `CHK(dout_oe_o, 1'b0)
      `CHK(irq_n_o, 1'b0)
      // modulator bits pass one clock late, unfiltered
      for (int k = 0; k < 20; k++) begin
         @(posedge clk_i);
         prev = v_bit_i;
         v_bit_i <= 3'($random(seed));
         #1;
         `CHK(v_bit_o, prev)
      end
      // current path: gain extremes, clamp corners, every current source
      wr(wzc_pkg::A_MASK, 2, 24'h000400);
      for (int k = 0; k < 12; k++) begin
         for (int p = 0; p < 3; p++) begin
            gain[p] = (k == 0) ? 12'h7FF : (k == 1) ? 12'h800 : 12'($random(seed));
            wr(6'(wzc_pkg::A_GAIN_A + p), 2, {12'h000, gain[p]});
         end
         ir = {24'($random(seed)), 24'($random(seed)), 24'($random(seed))};
         if (k == 2) ir = {24'h500000, 24'h800000, 24'h7FFFFF};
         ov = (k > 5) ? 3'($random(seed)) : 3'h0;
         wr(wzc_pkg::A_WAVEFORM_MODE_REGISTER, 1, {21'h0, 3'(k % 3)});
         sample(ir, ov, 48'h0);
         for (int p = 0; p < 3; p++) begin
            `CHK(i_pwr_o[24*p +: 24], ipath(ir[24*p +: 24], ov[p], gain[p]))
         end
         `CHK(irq_n, 1'b0)
         rdr(wzc_pkg::A_WAVE, 3);
         `CHK(rd, ipath(ir[24*(k%3) +: 24], ov[k%3], gain[k%3]))
         `CHK(irq_n_oe_o, 1'b1)
         rdr(wzc_pkg::A_CLEAR_ON_READ_STATUS, 2);
         `CHK(rd[10], 1'b1)
         `CHK(irq_n_oe_o, 1'b0)
      end
      // decimation: exactly eight over two to the rate hits in a run of eight samples
      for (int r = 0; r < 4; r++) begin
         wr(wzc_pkg::A_WAVEFORM_MODE_REGISTER, 1, {19'h0, 2'(r), 3'h0});
         n = 0;
         for (int k = 0; k < 8; k++) begin
            sample({3{24'($random(seed))}}, 3'h0, 48'h0);
            if (irq_n_oe_o === 1'b1) begin
               n++;
               rdr(wzc_pkg::A_CLEAR_ON_READ_STATUS, 2);
            end
         end
         `CHK(n, 8 >> r)
      end
      // sample-ready masked: register must keep its old word
      wr(wzc_pkg::A_WAVEFORM_MODE_REGISTER, 1, 24'h000000);
      wr(wzc_pkg::A_MASK, 2, 24'h000000);
      rdr(wzc_pkg::A_WAVE, 3);
      old = rd;
      sample(~{3{old}}, 3'h0, 48'h0);
      `CHK(irq_n_oe_o, 1'b0)
      rdr(wzc_pkg::A_WAVE, 3);
      `CHK(rd, old)
      // voltage phase B: settle negative, then cross upward twice
      for (int pass = 0; pass < 2; pass++) begin
         wr(wzc_pkg::A_MASK, 2, 24'h000400);
         wr(wzc_pkg::A_WAVEFORM_MODE_REGISTER, 1, 24'h000004);
         for (int k = 0; k < 40; k++) sample(72'h0, 3'h0, {16'h0, 16'hC000, 16'h0});
         rdr(wzc_pkg::A_WAVE, 3);
         `CHK(rd[23:16], 8'h00)
         `CHK(rd[15], 1'b1)
         wr(wzc_pkg::A_MASK, 2, 24'h000100);
         rdr(wzc_pkg::A_CLEAR_ON_READ_STATUS, 2);
         // raw sign flips at once, the filtered value lags behind
         sample(72'h0, 3'h0, {16'h0, 16'h4000, 16'h0});
         rdr(wzc_pkg::A_STATUS, 2);
         `CHK(rd[9:7], 3'b000)
         for (int k = 0; k < 39; k++) sample(72'h0, 3'h0, {16'h0, 16'h4000, 16'h0});
         rdr(wzc_pkg::A_STATUS, 2);
         `CHK(rd[9:7], 3'b010)
         `CHK(irq_n_oe_o, (pass == 0) ? 1'b1 : 1'b0)
         rdr(wzc_pkg::A_CLEAR_ON_READ_STATUS, 2);
         rdr(wzc_pkg::A_STATUS, 2);
         `CHK(rd[9:7], 3'b000)
         // drop the phase B enable for the second pass
         wr(wzc_pkg::A_MEASUREMENT_MODE_REGISTER, 1, 24'h000050);
      end
      stop_test();
   end
endmodule
`undef CHK
`default_nettype wire
